//--- mds_pkg.sv
package mds_pkg;
  localparam int STEPS = 16;
  localparam int DW = 16;
  localparam int DATA_WORDS = 32;
  localparam int TB_PERIOD_MS = 10;
  localparam int CLK_MHZ = 100;
  localparam int TICK_CYCLES = TB_PERIOD_MS * 1000 * CLK_MHZ;
  localparam logic [11:0] OFS_COUNTS = 12'h000;
  localparam logic [11:0] OFS_TIMER = 12'h004;
  localparam logic [11:0] OFS_PRESET = 12'h008;
  localparam logic [11:0] OFS_STEP = 12'h00C;
  localparam logic [11:0] OFS_CTRL = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [11:0] OFS_TIMEBASE = 12'h018;
  localparam logic [11:0] OFS_LAST = 12'h01C;
  localparam logic [11:0] OFS_MASK_BASE = 12'h020;
  localparam logic [11:0] OFS_DEST = 12'h024;
  localparam logic [11:0] OFS_EVT_ASSIGN = 12'h028;
  localparam logic [11:0] OFS_CPS = 12'h040;
  localparam logic [11:0] OFS_PATTERN = 12'h080;
  localparam logic [11:0] OFS_DATA = 12'h100;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_WORD_BIT = 1;
  localparam logic [4:0] PRESET_RST = 5'h01;
  localparam logic [4:0] LAST_RST = 5'h10;
  localparam logic [15:0] TIMEBASE_RST = 16'h0001;
  typedef enum logic [2:0] {
    ST_PROG = 3'b001,
    ST_RUN = 3'b010,
    ST_DONE = 3'b100
  } mds_state_t;
  typedef struct packed {
    logic [15:0] counts;
    logic [15:0] timer;
    logic [4:0] step;
  } mds_seq_t;
endpackage

//--- mds_tick.sv
`timescale 1ns/100ps
module mds_tick #(
  parameter int TICK_CYCLES = mds_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);
  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  always_comb begin
    tick_nxt = (cnt_r == LAST);
    cnt_nxt = tick_nxt ? '0 : cnt_r + CW'(1);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule // mds_tick

//--- mds_jog_edge.sv
`timescale 1ns/100ps
module mds_jog_edge (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scan,
  input wire logic jog,
  output logic rise
);
  logic prev_r;
  logic prev_nxt;

  // Jog edge per scan: the level is compared with the one seen at the previous scan.
  // scan edge
  always_comb begin
    prev_nxt = scan ? jog : prev_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  assign rise = scan & jog & ~prev_r;
endmodule // mds_jog_edge

//--- mds_sequencer.sv
// Contract
// - Sixteen steps, each with a sixteen-bit output pattern.
// - Output is current pattern ANDed with that step's mask word.
// - Mask words are read from consecutive locations from a base.
// - Word variant writes the masked result to a destination location.
// - Each jog rising edge advances one step regardless of timer or event.
// - Step timer runs only while start is asserted.
// - Timer counts only while step event is true; unassigned event means time only.
// - Counts in step equal to counts per step moves to next step.
// - Stepping stops after last used step or while reset is asserted.
// - Preset step loads on program-to-run and while reset is asserted.
// - Four status counters: counts, timer, preset and current step.
// - Preset counter is writable any time; others are read only.
// - Completion flag sets on last step finish, clears on reset.
// - Mask changes apply at once to the outputs.
// - Zero counts with true events advance one step per scan.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
module mds_sequencer #(
  parameter int TICK_CYCLES = mds_pkg::TICK_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SCAN,
  input wire logic START,
  input wire logic JOG,
  input wire logic SEQ_RESET,
  input wire logic [15:0] EVENT,
  output logic [15:0] OUT_DISCRETE,
  output logic DONE
);
  logic [15:0] cps_r [mds_pkg::STEPS];
  logic [15:0] pattern_r [mds_pkg::STEPS];
  logic [15:0] data_r [mds_pkg::DATA_WORDS];
  logic [4:0] preset_r;
  logic [4:0] last_r;
  logic [4:0] mask_base_r;
  logic [4:0] dest_r;
  logic [15:0] timebase_r;
  logic [15:0] evt_assign_r;
  logic run_r;
  logic word_r;
  logic run_prev_r;
  logic tb_pend_r;
  logic tb_pend_nxt;
  logic tick;
  logic jog_rise;
  mds_pkg::mds_state_t state_r;
  mds_pkg::mds_state_t state_nxt;
  mds_pkg::mds_seq_t seq_r;
  mds_pkg::mds_seq_t seq_nxt;
  logic [3:0] idx;
  logic [4:0] mask_idx;
  logic [15:0] masked;
  logic evt_ok;
  logic live;
  logic cnt_ok;
  logic adv;
  logic wr_en;
  logic [31:0] rdata_nxt;
  logic err_nxt;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [15:0] disc_r;
  logic done_r;

  function automatic logic [4:0] safe_step(input logic [4:0] s);
    return (s == 5'h00 || s > 5'h10) ? mds_pkg::PRESET_RST : s;
  endfunction

  mds_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk(CLOCK),
    .rst_n(RESETN),
    .tick(tick)
  );

  mds_jog_edge u_jog (
    .clk(CLOCK),
    .rst_n(RESETN),
    .scan(SCAN),
    .jog(JOG),
    .rise(jog_rise)
  );

  assign idx = 4'(seq_r.step - 5'h01);
  assign mask_idx = mask_base_r + {1'b0, idx};
  assign masked = pattern_r[idx] & data_r[mask_idx];
  assign evt_ok = ~evt_assign_r[idx] | EVENT[idx];
  assign live = run_r & SCAN & ~SEQ_RESET & (state_r == mds_pkg::ST_RUN);
  assign cnt_ok = live & ~jog_rise & START & evt_ok;
  assign wr_en = PSEL & PENABLE & PREADY & PWRITE;

  // Ticks between scans are held until the next scan consumes them; a tick on
  // the consuming cycle wins so it is kept; two ticks between scans count as one.
  always_comb begin
    tb_pend_nxt = tick | (tb_pend_r & ~SCAN);
  end

  always_comb begin
    state_nxt = state_r;
    seq_nxt = seq_r;
    adv = 1'b0;
    if (!run_r) begin
      state_nxt = mds_pkg::ST_PROG;
    end else if (SCAN) begin
      if (SEQ_RESET || state_r == mds_pkg::ST_PROG || !run_prev_r) begin
        seq_nxt.step = safe_step(preset_r);
        seq_nxt.counts = '0;
        seq_nxt.timer = '0;
        state_nxt = mds_pkg::ST_RUN;
      end else if (state_r == mds_pkg::ST_RUN) begin
        if (jog_rise) begin
          adv = 1'b1;
        end else if (cnt_ok) begin
          if (seq_r.counts == cps_r[idx]) begin
            adv = 1'b1;
          end else if (tb_pend_r) begin
            if (seq_r.timer + 16'h0001 >= timebase_r) begin
              seq_nxt.timer = '0;
              seq_nxt.counts = seq_r.counts + 16'h0001;
            end else begin
              seq_nxt.timer = seq_r.timer + 16'h0001;
            end
          end
        end
        if (adv) begin
          if (seq_r.step >= last_r) begin
            state_nxt = mds_pkg::ST_DONE;
          end else begin
            seq_nxt.step = seq_r.step + 5'h01;
            seq_nxt.counts = '0;
            seq_nxt.timer = '0;
          end
        end
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      state_r <= mds_pkg::ST_PROG;
      seq_r <= '{counts: 16'h0000, timer: 16'h0000, step: mds_pkg::PRESET_RST};
      tb_pend_r <= 1'b0;
      run_prev_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      seq_r <= seq_nxt;
      tb_pend_r <= tb_pend_nxt;
      run_prev_r <= run_r;
    end
  end

  always_comb begin
    rdata_nxt = '0;
    err_nxt = 1'b0;
    if (PADDR >= mds_pkg::OFS_CPS && PADDR < mds_pkg::OFS_PATTERN) begin
      rdata_nxt = {16'h0000, cps_r[PADDR[5:2]]};
    end else if (PADDR >= mds_pkg::OFS_PATTERN && PADDR < mds_pkg::OFS_PATTERN + 12'h040) begin
      rdata_nxt = {16'h0000, pattern_r[PADDR[5:2]]};
    end else if (PADDR >= mds_pkg::OFS_DATA && PADDR < mds_pkg::OFS_DATA + 12'h080) begin
      rdata_nxt = {16'h0000, data_r[PADDR[6:2]]};
    end else begin
      unique case (PADDR)
        mds_pkg::OFS_COUNTS: rdata_nxt = {16'h0000, seq_r.counts};
        mds_pkg::OFS_TIMER: rdata_nxt = {16'h0000, seq_r.timer};
        mds_pkg::OFS_PRESET: rdata_nxt = {27'h0000000, preset_r};
        mds_pkg::OFS_STEP: rdata_nxt = {27'h0000000, seq_r.step};
        mds_pkg::OFS_CTRL: rdata_nxt = {30'h00000000, word_r, run_r};
        mds_pkg::OFS_STATUS: rdata_nxt = {31'h00000000, done_r};
        mds_pkg::OFS_TIMEBASE: rdata_nxt = {16'h0000, timebase_r};
        mds_pkg::OFS_LAST: rdata_nxt = {27'h0000000, last_r};
        mds_pkg::OFS_MASK_BASE: rdata_nxt = {27'h0000000, mask_base_r};
        mds_pkg::OFS_DEST: rdata_nxt = {27'h0000000, dest_r};
        mds_pkg::OFS_EVT_ASSIGN: rdata_nxt = {16'h0000, evt_assign_r};
        default: err_nxt = 1'b1;
      endcase
    end
  end

  // Zero-wait slave: the answer is prepared in the setup cycle.
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= PSEL & ~PENABLE;
      prdata_r <= (PSEL & ~PENABLE & ~PWRITE) ? rdata_nxt : '0;
      pslverr_r <= PSEL & ~PENABLE & err_nxt;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      preset_r <= mds_pkg::PRESET_RST;
      last_r <= mds_pkg::LAST_RST;
      mask_base_r <= '0;
      dest_r <= '0;
      timebase_r <= mds_pkg::TIMEBASE_RST;
      evt_assign_r <= '0;
      run_r <= 1'b0;
      word_r <= 1'b0;
    end else if (wr_en) begin
      unique case (PADDR)
        mds_pkg::OFS_PRESET: preset_r <= PWDATA[4:0];
        mds_pkg::OFS_CTRL: begin
          run_r <= PWDATA[mds_pkg::CTRL_RUN_BIT];
          word_r <= PWDATA[mds_pkg::CTRL_WORD_BIT];
        end
        mds_pkg::OFS_TIMEBASE: timebase_r <= PWDATA[15:0];
        mds_pkg::OFS_LAST: last_r <= PWDATA[4:0];
        mds_pkg::OFS_MASK_BASE: mask_base_r <= PWDATA[4:0];
        mds_pkg::OFS_DEST: dest_r <= PWDATA[4:0];
        mds_pkg::OFS_EVT_ASSIGN: evt_assign_r <= PWDATA[15:0];
        default: ;
      endcase
    end
  end

  for (genvar g = 0; g < mds_pkg::STEPS; g++) begin : g_step
    always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
        cps_r[g] <= '0;
        pattern_r[g] <= '0;
      end else if (wr_en && PADDR == mds_pkg::OFS_CPS + 12'(4 * g)) begin
        cps_r[g] <= PWDATA[15:0];
      end else if (wr_en && PADDR == mds_pkg::OFS_PATTERN + 12'(4 * g)) begin
        pattern_r[g] <= PWDATA[15:0];
      end
    end
  end

  // Software writes win over the word output in the same cycle; the word is
  // rewritten on the next edge anyway.
  for (genvar g = 0; g < mds_pkg::DATA_WORDS; g++) begin : g_data
    always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
        data_r[g] <= '0;
      end else if (wr_en && PADDR == mds_pkg::OFS_DATA + 12'(4 * g)) begin
        data_r[g] <= PWDATA[15:0];
      end else if (run_r && word_r && dest_r == 5'(g)) begin
        data_r[g] <= masked;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      disc_r <= '0;
      done_r <= 1'b0;
    end else begin
      disc_r <= (run_r && !word_r) ? masked : '0;
      done_r <= (state_nxt == mds_pkg::ST_DONE);
    end
  end

  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign OUT_DISCRETE = disc_r;
  assign DONE = done_r;

  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  AST_MASK_AND: assert property (run_r && !word_r
    |=> OUT_DISCRETE == $past(pattern_r[idx] & data_r[mask_base_r + seq_r.step - 5'h01]))
    else $error("Discrete output is not pattern AND mask.");
  AST_WORD_DEST: assert property (run_r && word_r && !wr_en
    |=> data_r[$past(dest_r)]
      == $past(pattern_r[idx] & data_r[mask_base_r + seq_r.step - 5'h01]))
    else $error("Word output not written to destination.");
  AST_JOG_STEP: assert property (live && jog_rise && seq_r.step < last_r
    |=> seq_r.step == $past(seq_r.step) + 5'h01 && seq_r.counts == 16'h0000)
    else $error("Jog edge did not advance one step.");
  AST_START_HOLD: assert property (live && !jog_rise && !START
    |=> $stable(seq_r) && state_r == mds_pkg::ST_RUN)
    else $error("Timer moved without start.");
  AST_EVT_HOLD: assert property (live && !jog_rise && !evt_ok |=> $stable(seq_r))
    else $error("Timer moved with event false.");
  AST_COUNT_ADV: assert property (cnt_ok && seq_r.counts == cps_r[idx]
    && seq_r.step < last_r
    |=> seq_r.step == $past(seq_r.step) + 5'h01 && seq_r.timer == 16'h0000)
    else $error("Count match did not advance.");
  AST_DONE_SET: assert property (live && adv && seq_r.step >= last_r
    |=> state_r == mds_pkg::ST_DONE && DONE)
    else $error("Completion flag not set after last step.");
  AST_DONE_STOP: assert property (state_r == mds_pkg::ST_DONE
    && !(SCAN && SEQ_RESET) && run_r
    |=> $stable(seq_r) && state_r == mds_pkg::ST_DONE)
    else $error("Sequencer moved after completion.");
  AST_PRESET_LOAD: assert property (run_r && SCAN && SEQ_RESET
    |=> seq_r.step == safe_step($past(preset_r)) && seq_r.counts == 16'h0000 && !DONE)
    else $error("Preset step not loaded on reset.");
  AST_PRESET_WR: assert property (wr_en && PADDR == mds_pkg::OFS_PRESET
    |=> preset_r == $past(PWDATA[4:0]))
    else $error("Preset write not taken.");
  AST_TB_COUNT: assert property (cnt_ok && tb_pend_r && seq_r.counts != cps_r[idx]
    && seq_r.timer + 16'h0001 >= timebase_r
    |=> seq_r.counts == $past(seq_r.counts) + 16'h0001)
    else $error("Timebase period did not add a count.");

  CVR_DONE: cover property (state_r == mds_pkg::ST_RUN ##1 state_r == mds_pkg::ST_DONE);
  CVR_JOG: cover property (live && jog_rise);
  CVR_WORD: cover property (run_r && word_r && masked != 16'h0000);
endmodule // mds_sequencer

//--- mds_ctl_model.sv
`timescale 1ns/100ps
module mds_ctl_model (
  input wire logic clk,
  output logic scan,
  output logic start,
  output logic jog,
  output logic seq_reset,
  output logic [15:0] event_lines
);
  initial begin
    scan = 1'h0;
    start = 1'h0;
    jog = 1'h0;
    seq_reset = 1'h0;
    event_lines = 16'h0000;
  end

  // The ladder rungs change only between scans, so the levels move at an edge.
  task automatic set_in(input logic s, input logic j, input logic r, input logic [15:0] e);
    @(posedge clk);
    start <= s;
    jog <= j;
    seq_reset <= r;
    event_lines <= e;
  endtask

  task automatic do_scan();
    @(posedge clk);
    scan <= 1'h1;
    @(posedge clk);
    scan <= 1'h0;
  endtask
endmodule // mds_ctl_model

//--- mds_sequencer_tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin mismatches++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module mds_sequencer_tb_top;
  logic clock, resetn, psel, penable, pwrite, pready, pslverr, scan, start, jog, sres, done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] evt, out_d;
  logic [15:0] pat [16];
  logic [15:0] dat [32];
  logic [33:0] notes [$];
  logic [33:0] nt;
  int mismatches, comparisons, seed, cyc, k;

  mds_sequencer #(.TICK_CYCLES(20)) uut (.CLOCK(clock), .RESETN(resetn), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SCAN(scan), .START(start), .JOG(jog),
    .SEQ_RESET(sres), .EVENT(evt), .OUT_DISCRETE(out_d), .DONE(done));
  mds_ctl_model ctl (.clk(clock), .scan(scan), .start(start), .jog(jog),
    .seq_reset(sres), .event_lines(evt));

  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc > 20000) begin
      mismatches++;
      close_out();
    end
  end

  // Each finished transfer takes the oldest note: {write, slave error, read data}.
  always @(posedge clock) begin
    if (psel && penable && pready === 1'h1) begin
      nt = notes.pop_front();
      `CHK("pslverr", nt[32], pslverr)
      if (!nt[33]) `CHK("prdata", nt[31:0], prdata)
    end
    if (psel && !penable) `CHK("pready", 1'h0, pready)
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
    notes.push_back({w, e, d});
    @(posedge clock);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0000_0000;
    @(posedge clock);
    penable <= 1'h1;
    @(posedge clock iff (pready === 1'h1));
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic chk_step(input int s);
    @(posedge clock);
    @(negedge clock);
    `CHK("out", pat[s-1] & dat[s-1], out_d)
    apb(1'h0, mds_pkg::OFS_STEP, 32'(s), 1'h0);
  endtask

  initial begin
    seed = 39465;
    resetn = 1'h0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (16) @(posedge clock);
    resetn <= 1'h1;
    apb(1'h0, mds_pkg::OFS_PRESET, 32'h0000_0001, 1'h0);
    apb(1'h0, mds_pkg::OFS_LAST, 32'h0000_0010, 1'h0);
    apb(1'h1, mds_pkg::OFS_COUNTS, 32'h0000_0007, 1'h0);
    apb(1'h0, mds_pkg::OFS_COUNTS, 32'h0000_0000, 1'h0);
    apb(1'h0, 12'hFFC, 32'h0000_0000, 1'h1);
    for (k = 0; k < 16; k++) begin
      pat[k] = 16'($random(seed));
      dat[k] = 16'($random(seed));
      apb(1'h1, mds_pkg::OFS_PATTERN + 12'(4 * k), {16'h0000, pat[k]}, 1'h0);
      apb(1'h1, mds_pkg::OFS_DATA + 12'(4 * k), {16'h0000, dat[k]}, 1'h0);
    end
    apb(1'h1, mds_pkg::OFS_LAST, 32'h0000_0004, 1'h0);
    apb(1'h1, mds_pkg::OFS_CTRL, 32'h0000_0001, 1'h0);
    ctl.set_in(1'h1, 1'h0, 1'h0, 16'h0000);
    // zero counts give one step per scan; the first scan loads the preset.
    for (k = 1; k <= 5; k++) begin
      ctl.do_scan();
      chk_step(k > 4 ? 4 : k);
    end
    // stops at the last used step
    `CHK("done", 1'h1, done)
    apb(1'h0, mds_pkg::OFS_STATUS, 32'h0000_0001, 1'h0);
    apb(1'h1, mds_pkg::OFS_LAST, 32'h0000_0010, 1'h0);
    apb(1'h1, mds_pkg::OFS_PRESET, 32'h0000_0003, 1'h0);
    ctl.set_in(1'h0, 1'h0, 1'h1, 16'h0000);
    ctl.do_scan();
    chk_step(3);
    `CHK("done", 1'h0, done)
    ctl.set_in(1'h0, 1'h0, 1'h0, 16'h0000);
    ctl.do_scan();
    chk_step(3);
    ctl.set_in(1'h0, 1'h1, 1'h0, 16'h0000);
    ctl.do_scan();
    chk_step(4);
    dat[3] = 16'($random(seed));
    apb(1'h1, mds_pkg::OFS_DATA + 12'h00C, {16'h0000, dat[3]}, 1'h0);
    chk_step(4);
    apb(1'h1, mds_pkg::OFS_EVT_ASSIGN, 32'h0000_0008, 1'h0);
    ctl.set_in(1'h1, 1'h0, 1'h0, 16'hFFF7);
    ctl.do_scan();
    chk_step(4);
    ctl.set_in(1'h1, 1'h0, 1'h0, 16'h0008);
    ctl.do_scan();
    chk_step(5);
    apb(1'h1, mds_pkg::OFS_DEST, 32'h0000_001F, 1'h0);
    apb(1'h1, mds_pkg::OFS_CTRL, 32'h0000_0003, 1'h0);
    repeat (2) @(posedge clock);
    @(negedge clock);
    `CHK("out", 16'h0000, out_d)
    apb(1'h0, mds_pkg::OFS_DATA + 12'h07C, {16'h0000, pat[4] & dat[4]}, 1'h0);
    apb(1'h1, mds_pkg::OFS_CTRL, 32'h0000_0001, 1'h0);
    apb(1'h1, mds_pkg::OFS_CPS + 12'h010, 32'h0000_0002, 1'h0);
    apb(1'h1, mds_pkg::OFS_TIMEBASE, 32'h0000_0002, 1'h0);
    // Each wait spans a full tick period, so a tick is pending at every scan.
    for (k = 1; k <= 4; k++) begin
      repeat (20) @(posedge clock);
      ctl.do_scan();
      apb(1'h0, mds_pkg::OFS_TIMER, 32'(k % 2), 1'h0);
      apb(1'h0, mds_pkg::OFS_COUNTS, 32'(k / 2), 1'h0);
    end
    repeat (20) @(posedge clock);
    ctl.do_scan();
    chk_step(6);
    repeat (2) @(posedge clock);
    close_out();
  end
endmodule // mds_sequencer_tb_top
